// >>> include/dbsr_pkg.sv
// Constants, field layouts and state types of the boot-strap and reset pin controller.
// Functional notes
// - Release all sixteen processor lines in normal running.
// - Drive boot switches during power-on and full reset.
// - Core select resets to zero, then follows register.
// - Packet clock select from switches 13:11 or register.
// - Latch enable and local reset default high, follow register.
// - NMI defaults high; register sets it once unlocked.
// - Both frame-sync outputs follow the differential input.
`default_nettype none
package dbsr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned POWERON_NS = 100000;
    localparam int unsigned POWERON_CYCLES = (POWERON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] POWERON_LAST = 12'(POWERON_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UNLOCK = 8'h04;
    localparam logic [7:0] OFS_NMI = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_GPIO_IN = 8'h10;
    localparam logic [7:0] NMI_UNLOCK_KEY = 8'h5a;

    // Status word field positions.
    localparam int unsigned ST_DRIVE = 0;
    localparam int unsigned ST_FULL = 1;
    localparam int unsigned ST_UNLOCK = 2;
    localparam int unsigned ST_PHASE_LSB = 4;
    localparam int unsigned ST_SW_LSB = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchroniser vector layout.
    localparam int unsigned SYNC_W = 35;
    localparam int unsigned SY_TDM_N = 0;
    localparam int unsigned SY_TDM_P = 1;
    localparam int unsigned SY_FULL_N = 2;
    localparam int unsigned SY_SW_LSB = 3;
    localparam int unsigned SY_GPIO_LSB = 19;
    localparam int unsigned SW_PCLK_LSB = 11;

    localparam logic [15:0] OE_N_RELEASE = 16'hffff;
    localparam logic [15:0] OE_N_DRIVE = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    // Power-on to run and run to full reset each flip a single bit.
    typedef enum logic [1:0] {
        DBSR_POWERON = 2'b00,
        DBSR_RUN = 2'b01,
        DBSR_FULLRST = 2'b11
    } dbsr_phase_e;

    typedef struct packed {
        logic pclk_val;
        logic pclk_src;
        logic lreset_n;
        logic latch_en_n;
        logic [3:0] core_sel;
    } dbsr_ctrl_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        dbsr_ctrl_s ctrl;
        logic unlocked;
        logic nmi_n;
        dbsr_phase_e phase;
        logic [11:0] por_cnt;
        logic [15:0] gpio_out;
        logic [15:0] gpio_oe_n;
        logic pclk;
        logic tdm_a;
        logic tdm_b;
    } dbsr_state_s;

    localparam dbsr_ctrl_s CTRL_RESET = '{pclk_val: 1'b0, pclk_src: 1'b0, lreset_n: 1'b1,
                                          latch_en_n: 1'b1, core_sel: 4'h0};

    localparam dbsr_state_s STATE_RESET = '{ack: 1'b0, dat: 32'h0000_0000, ctrl: CTRL_RESET,
                                            unlocked: 1'b0, nmi_n: 1'b1, phase: DBSR_POWERON,
                                            por_cnt: 12'h000, gpio_out: 16'h0000,
                                            gpio_oe_n: OE_N_DRIVE, pclk: 1'b0,
                                            tdm_a: 1'b0, tdm_b: 1'b0};

endpackage : dbsr_pkg
`default_nettype wire

// >>> rtl/dbsr_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
`timescale 1ns/10ps
`default_nettype none
module dbsr_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } dbsr_sync_s;

    dbsr_sync_s st;
    dbsr_sync_s next_st;

    // The first stage feeds only the second, so metastability never reaches logic.
    always_comb begin
        next_st.meta = async_i;
        next_st.safe = st.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.safe;

endmodule : dbsr_sync
`default_nettype wire

// >>> rtl/dbsr_top.sv
// Boot-strap, reset and interrupt pin controller with a Wishbone register slave.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dbsr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] boot_switch_inputs_i,
    input wire logic proc_full_reset_n_i,
    input wire logic [15:0] proc_gpio_i,
    output logic [15:0] proc_gpio_o,
    output logic [15:0] proc_gpio_oe_n_o,
    output logic [3:0] proc_core_select_o,
    output logic packet_clock_select_o,
    output logic local_reset_irq_latch_en_n_o,
    output logic proc_nonmaskable_irq_n_o,
    output logic proc_local_reset_n_o,
    input wire logic tdm_frame_sync_diff_p_i,
    input wire logic tdm_frame_sync_diff_n_i,
    output logic tdm_port0_frame_sync_out_a_o,
    output logic tdm_port0_frame_sync_out_b_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [dbsr_pkg::SYNC_W-1:0] sy;
    logic [15:0] sw_sync;
    logic [15:0] gpio_sync;
    logic full_n_sync;
    logic tdm_level;

    dbsr_sync #(
        .W(dbsr_pkg::SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({proc_gpio_i, boot_switch_inputs_i, proc_full_reset_n_i,
                  tdm_frame_sync_diff_p_i, tdm_frame_sync_diff_n_i}),
        .sync_o(sy)
    );

    // High only when the true half is high and the complement low; a collapsed pair reads as low.
    assign sw_sync = sy[dbsr_pkg::SY_SW_LSB +: 16];
    assign gpio_sync = sy[dbsr_pkg::SY_GPIO_LSB +: 16];
    assign full_n_sync = sy[dbsr_pkg::SY_FULL_N];
    assign tdm_level = sy[dbsr_pkg::SY_TDM_P] & ~sy[dbsr_pkg::SY_TDM_N];

    ////////////////////////////////////////////////////////////////////////////////
    // State and next-state logic.
    dbsr_pkg::dbsr_state_s st;
    dbsr_pkg::dbsr_state_s next_st;
    logic req;
    logic wr;
    logic [7:0] adr;
    logic [31:0] status;

    assign req = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wr = req & wb_we_i;
    assign adr = {wb_adr_i[7:2], 2'b00};

    // Status gathers the strap phase and the live switch and reset pins.
    always_comb begin
        status = 32'h0000_0000;
        status[dbsr_pkg::ST_DRIVE] = (st.phase != dbsr_pkg::DBSR_RUN);
        status[dbsr_pkg::ST_FULL] = ~full_n_sync;
        status[dbsr_pkg::ST_UNLOCK] = st.unlocked;
        status[dbsr_pkg::ST_PHASE_LSB +: 2] = st.phase;
        status[dbsr_pkg::ST_SW_LSB +: 16] = sw_sync;
    end

    always_comb begin
        next_st = st;
        next_st.ack = req;
        // Bus: one wait state, unmapped offsets read zero and ignore writes.
        if (req) begin
            next_st.dat = 32'h0000_0000;
            unique case (adr)
                dbsr_pkg::OFS_CTRL: next_st.dat[7:0] = st.ctrl;
                dbsr_pkg::OFS_UNLOCK: next_st.dat[0] = st.unlocked;
                dbsr_pkg::OFS_NMI: next_st.dat[0] = st.nmi_n;
                dbsr_pkg::OFS_STATUS: next_st.dat = status;
                dbsr_pkg::OFS_GPIO_IN: next_st.dat[15:0] = gpio_sync;
                default: next_st.dat = 32'h0000_0000;
            endcase
        end
        if (wr && wb_sel_i[0]) begin
            if (adr == dbsr_pkg::OFS_CTRL) begin
                next_st.ctrl = wb_dat_i[7:0];
            end
            if (adr == dbsr_pkg::OFS_UNLOCK) begin
                next_st.unlocked = (wb_dat_i[7:0] == dbsr_pkg::NMI_UNLOCK_KEY);
            end
            // A locked write is dropped so a stray store cannot fire the interrupt.
            if (adr == dbsr_pkg::OFS_NMI && st.unlocked) begin
                next_st.nmi_n = wb_dat_i[0];
            end
        end
        // Strap phase: power-on window, then track the full-reset pin.
        unique case (st.phase)
            dbsr_pkg::DBSR_POWERON: begin
                if (st.por_cnt == dbsr_pkg::POWERON_LAST) begin
                    next_st.phase = full_n_sync ? dbsr_pkg::DBSR_RUN : dbsr_pkg::DBSR_FULLRST;
                end else begin
                    next_st.por_cnt = st.por_cnt + 12'h001;
                end
            end
            dbsr_pkg::DBSR_FULLRST: begin
                if (full_n_sync) begin
                    next_st.phase = dbsr_pkg::DBSR_RUN;
                end
            end
            dbsr_pkg::DBSR_RUN: begin
                if (!full_n_sync) begin
                    next_st.phase = dbsr_pkg::DBSR_FULLRST;
                end
            end
            default: begin
                next_st.phase = dbsr_pkg::DBSR_POWERON;
                next_st.por_cnt = 12'h000;
            end
        endcase
        // Drive switches while strapping, release every line when running.
        next_st.gpio_out = sw_sync;
        next_st.gpio_oe_n = (next_st.phase == dbsr_pkg::DBSR_RUN) ?
                            dbsr_pkg::OE_N_RELEASE : dbsr_pkg::OE_N_DRIVE;
        // Packet clock: any of switches 13:11 set, unless the register overrides.
        next_st.pclk = st.ctrl.pclk_src ? st.ctrl.pclk_val :
                       (|sw_sync[dbsr_pkg::SW_PCLK_LSB +: 3]);
        next_st.tdm_a = tdm_level;
        next_st.tdm_b = tdm_level;
    end

    // Own reset loads every pin default before software can write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= dbsr_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all taken straight from state flops.
    assign wb_dat_o = st.dat;
    assign wb_ack_o = st.ack;
    assign proc_gpio_o = st.gpio_out;
    assign proc_gpio_oe_n_o = st.gpio_oe_n;
    assign proc_core_select_o = st.ctrl.core_sel;
    assign packet_clock_select_o = st.pclk;
    assign local_reset_irq_latch_en_n_o = st.ctrl.latch_en_n;
    assign proc_nonmaskable_irq_n_o = st.nmi_n;
    assign proc_local_reset_n_o = st.ctrl.lreset_n;
    assign tdm_port0_frame_sync_out_a_o = st.tdm_a;
    assign tdm_port0_frame_sync_out_b_o = st.tdm_b;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_gpio_release: assert property (
        (st.phase == dbsr_pkg::DBSR_POWERON && st.por_cnt == dbsr_pkg::POWERON_LAST
         && full_n_sync) |=> (proc_gpio_oe_n_o == 16'hffff) ##1 (proc_gpio_oe_n_o == 16'hffff)
    ) else $error("lines not released after power-on window");

    a_strap_drive: assert property (
        !full_n_sync |=> (proc_gpio_oe_n_o == 16'h0000) && (proc_gpio_o == $past(sw_sync))
    ) else $error("switches not driven during full reset");

    a_reset_defaults: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> proc_core_select_o == 4'h0 && local_reset_irq_latch_en_n_o
                  && proc_local_reset_n_o && proc_nonmaskable_irq_n_o
                  && proc_gpio_oe_n_o == 16'h0000
    ) else $error("defaults not loaded by reset");

    a_core_follow: assert property (
        (wr && wb_sel_i[0] && adr == dbsr_pkg::OFS_CTRL)
        |=> proc_core_select_o == $past(wb_dat_i[3:0]) && wb_ack_o
    ) else $error("core select did not follow write");

    a_pclk_source: assert property (
        !st.ctrl.pclk_src ##1 !st.ctrl.pclk_src
        |-> packet_clock_select_o == $past(|sw_sync[13:11])
    ) else $error("packet clock select not from switches");

    a_latch_lreset: assert property (
        (wr && wb_sel_i[0] && adr == dbsr_pkg::OFS_CTRL)
        |=> local_reset_irq_latch_en_n_o == $past(wb_dat_i[4])
            && proc_local_reset_n_o == $past(wb_dat_i[5])
    ) else $error("latch enable or local reset did not follow write");

    a_nmi_locked: assert property (
        (wr && adr == dbsr_pkg::OFS_NMI && !st.unlocked) |=> $stable(proc_nonmaskable_irq_n_o)
    ) else $error("locked write changed interrupt line");

    a_nmi_unlocked: assert property (
        (wr && wb_sel_i[0] && adr == dbsr_pkg::OFS_NMI && st.unlocked)
        |=> proc_nonmaskable_irq_n_o == $past(wb_dat_i[0])
    ) else $error("unlocked write did not set interrupt line");

    a_tdm_follow: assert property (
        1'b1 |=> tdm_port0_frame_sync_out_a_o == $past(tdm_level)
                 && tdm_port0_frame_sync_out_b_o == $past(tdm_level)
    ) else $error("frame sync outputs do not track input");

    a_ack_once: assert property (
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held longer than one cycle");

    c_ctrl_write: cover property (wr && adr == dbsr_pkg::OFS_CTRL);
    c_full_reset: cover property (st.phase == dbsr_pkg::DBSR_RUN ##1 !full_n_sync);
    c_nmi_fire: cover property (wr && adr == dbsr_pkg::OFS_NMI && st.unlocked ##1 !st.nmi_n);
    c_released: cover property ($rose(proc_gpio_oe_n_o[0]));

endmodule : dbsr_top
`default_nettype wire

// >>> test/dbsr_proc_model.sv
// Processor-side model: resolves the shared lines and latches the boot straps.
`timescale 1ns/10ps
`default_nettype none
module dbsr_proc_model (
    input wire logic [15:0] ctrl_gpio_i,
    input wire logic [15:0] ctrl_oe_n_i,
    input wire logic [15:0] own_gpio_i,
    input wire logic full_reset_n_i,
    output logic [15:0] line_o,
    output logic [15:0] boot_cfg_o
);
    // Each line carries the controller value while it drives, else the processor's own.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            line_o[i] = ctrl_oe_n_i[i] ? own_gpio_i[i] : ctrl_gpio_i[i];
        end
    end
    // The boot configuration is captured when full reset is released.
    initial boot_cfg_o = 16'h0000;
    always @(posedge full_reset_n_i) begin
        boot_cfg_o <= line_o;
    end
endmodule : dbsr_proc_model
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the boot-strap and reset pin controller.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i, rst_i, cyc, stb, we, full_n, tdm_p, tdm_n, pclk, latch_n, nmi_n, lrst_n;
    logic tdm_a, tdm_b, ack;
    logic [7:0] adr;
    logic [3:0] sel, core;
    logic [31:0] wdat, rdat, rd;
    logic [15:0] sw, own, line, gpo, oe_n, boot;
    int failures, check_count;
    // CTRL rows: written byte, expected {pclk, lreset_n, latch_n, core}.
    logic [7:0] row_wd[4] = '{8'h0f, 8'h30, 8'hc5, 8'h6a};
    logic [6:0] row_exp[4] = '{7'h4f, 7'h70, 7'h45, 7'h2a};
    dbsr_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .boot_switch_inputs_i(sw), .proc_full_reset_n_i(full_n), .proc_gpio_i(line),
        .proc_gpio_o(gpo), .proc_gpio_oe_n_o(oe_n), .proc_core_select_o(core),
        .packet_clock_select_o(pclk), .local_reset_irq_latch_en_n_o(latch_n),
        .proc_nonmaskable_irq_n_o(nmi_n), .proc_local_reset_n_o(lrst_n),
        .tdm_frame_sync_diff_p_i(tdm_p), .tdm_frame_sync_diff_n_i(tdm_n),
        .tdm_port0_frame_sync_out_a_o(tdm_a), .tdm_port0_frame_sync_out_b_o(tdm_b));
    dbsr_proc_model proc_u (.ctrl_gpio_i(gpo), .ctrl_oe_n_i(oe_n), .own_gpio_i(own),
        .full_reset_n_i(full_n), .line_o(line), .boot_cfg_o(boot));
    ////////////////////////////////////////////////////////////////////////////////
    // A 50 ns clock.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Compare and count; report at once on a difference.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cycles
    // Classic single cycle; held until ack is sampled, so the slave sets the pace.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        // A slave that never answers ends the run as a counted mismatch.
        if (ack !== 1'b1) begin
            failures++;
            $display("mismatch wb_ack expected 1 seen %b", ack);
            end_sim();
        end else begin
            rd = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
            @(posedge clk_i);
        end
    endtask : wb
    task automatic defaults();
        chk("core", 32'h0, 32'(core));
        chk("pins", 32'h7, {29'h0, latch_n, lrst_n, nmi_n});
        chk("oe_n", 32'h0, 32'(oe_n));
    endtask : defaults
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, sel, wdat} = '0;
        failures = 0; check_count = 0; full_n = 1'b1; tdm_p = 1'b0; tdm_n = 1'b1;
        sw = 16'h1a5c; own = 16'h9c36;
        cycles(20);
        rst_i <= 1'b0;
        cycles(1);
        defaults();
        cycles(8);
        chk("strap", 32'h1a5c, 32'(line));
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl_rst", 32'h30, rd);
        cycles(2000);
        chk("released", 32'hffff, 32'(oe_n));
        chk("own_line", 32'h9c36, 32'(line));
        wb(1'b0, 8'h10, 32'h0);
        chk("gpio_in", 32'h9c36, rd);
        wb(1'b0, 8'h0c, 32'h0);
        chk("status_sw", 32'h1a5c, 32'(rd[31:16]));
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'h00, 32'(row_wd[i]));
            chk("ctrl_pins", 32'(row_exp[i]), {25'h0, pclk, lrst_n, latch_n, core});
        end
        // Switch bits 13:11 all low give a low packet clock select.
        wb(1'b1, 8'h00, 32'h30);
        sw <= 16'hc7ff;
        cycles(5);
        chk("pclk_sw", 32'h0, 32'(pclk));
        wb(1'b1, 8'h08, 32'h0);
        chk("nmi_locked", 32'h1, 32'(nmi_n));
        wb(1'b1, 8'h04, 32'h5a);
        wb(1'b1, 8'h08, 32'h0);
        chk("nmi_open", 32'h0, 32'(nmi_n));
        wb(1'b0, 8'h24, 32'h0);
        chk("unmapped", 32'h0, rd);
        full_n <= 1'b0;
        cycles(5);
        chk("full_oe", 32'h0, 32'(oe_n));
        chk("full_line", 32'hc7ff, 32'(line));
        full_n <= 1'b1;
        cycles(5);
        chk("boot_cfg", 32'hc7ff, 32'(boot));
        chk("rerelease", 32'hffff, 32'(oe_n));
        for (int i = 0; i < 2; i++) begin
            tdm_p <= ~tdm_p; tdm_n <= ~tdm_n;
            cycles(5);
            chk("tdm", {30'h0, {2{~tdm_n}}}, {30'h0, tdm_a, tdm_b});
        end
        // A second reset in mid-run restores every default.
        rst_i <= 1'b1;
        cycles(3);
        rst_i <= 1'b0;
        cycles(1);
        defaults();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
